// file: rtl/capture_mem_if.sv
// Interface: write and read port between slot logic and the receive capture store
`timescale 1ns/1ps
interface capture_mem_if #(
  parameter int LANES = 8,
  parameter int WORD_W = 16
);
  logic [LANES-1:0] wr_en;
  logic [WORD_W-1:0] wr_data;
  logic [$clog2(LANES)-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;

  modport writer(output wr_en, output wr_data, output rd_addr, input rd_data);
  modport store(input wr_en, input wr_data, input rd_addr, output rd_data);
endinterface

// file: rtl/pcm_capture_mem.sv
// Module: per-lane store of the last received sample, registered read port
`timescale 1ns/1ps
module pcm_capture_mem #(
  parameter int LANES = 8,
  parameter int WORD_W = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  capture_mem_if.store mem
);

  logic [WORD_W-1:0] words [LANES];

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_word
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          words[g] <= '0;
        end else if (mem.wr_en[g]) begin
          words[g] <= mem.wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mem.rd_data <= '0;
    end else begin
      mem.rd_data <= words[mem.rd_addr];
    end
  end

endmodule

// file: rtl/pcm_slot_map_control.sv
// Module: PCM slot map control with AXI4-Lite registers and slot steering
`timescale 1ns/1ps

// Function
// RULE1 - Transmit lane 3 on bit 7 turns that lane on; resets off.
// RULE2 - Bits 3:0 of each map register select the bus slot of that lane.
// RULE3 - Receive lane n on bit 7 enables reception of lane n; resets off.
// RULE4 - Receive lane n slot selector resets to n, lanes 0 to 7.
// RULE5 - Transmit lane 3 slot selector resets to slot zero.
// RULE6 - Software sets receive interleave only when port rate is half bus rate.
// RULE7 - Receive interleave lets two lanes share one slot alternately.
// RULE8 - In receive interleave the sample LSB picks which sharing lane gets it.
// RULE9 - Control bit 1 enables transmit interleave; software uses it at half rate.
// RULE10 - Master enable bit 0 switches the whole subsystem on; resets off.
// RULE11 - Disabled transmit slot drives low, or floats when float option set.
// RULE12 - Reserved bits read zero and ignore writes.
module pcm_slot_map_control
  import pcm_slot_map_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic frame_start_in,
  input wire logic slot_tick_in,
  input wire logic [SLOT_W-1:0] slot_index_in,
  input wire logic rx_sample_valid_in,
  input wire logic [SAMPLE_W-1:0] rx_sample_in,
  input wire logic [SAMPLE_W-1:0] tx_feed_lane3_in,
  output logic tx_feed_lane3_taken_out,
  output logic [SAMPLE_W-1:0] tx_data_out,
  output logic tx_drive_out,
  output logic [RX_LANES-1:0] rx_lane_got_out,
  input wire logic [$clog2(RX_LANES)-1:0] cap_rd_lane_in,
  output logic [SAMPLE_W-1:0] cap_rd_data_out,
  output logic audio_on_out
);

  // Control registers
  logic tx_lane3_on;
  logic [SLOT_W-1:0] tx_lane3_slot_select;
  logic tx_lane3_float_when_off;
  logic [RX_LANES-1:0] rx_lane_on;
  logic [SLOT_W-1:0] rx_lane_slot_select [RX_LANES];
  logic rx_interleave;
  logic tx_interleave;
  logic audio_master_enable;
  logic frame_parity;

  // Write channel: address and data are taken together, one write in flight
  wire wr_fire = s_axi_awvalid_in & s_axi_wvalid_in & ~s_axi_bvalid_out;
  wire wr_low = wr_fire & s_axi_wstrb_in[0];
  wire [7:0] wbyte = s_axi_wdata_in[7:0];
  wire wr_hit_tx3 = (s_axi_awaddr_in == OFS_TX_LANE3_MAP);
  wire wr_hit_ctrl = (s_axi_awaddr_in == OFS_DATA_CTRL);
  wire wr_hit_master = (s_axi_awaddr_in == OFS_MASTER_EN);
  wire wr_hit_float = (s_axi_awaddr_in == OFS_TX_FLOAT);
  logic [RX_LANES-1:0] wr_hit_rx;
  wire wr_mapped = wr_hit_tx3 | wr_hit_ctrl | wr_hit_master | wr_hit_float | (|wr_hit_rx);

  assign s_axi_awready_out = wr_fire;
  assign s_axi_wready_out = wr_fire;

  // Read channel: one read in flight, data registered
  wire rd_fire = s_axi_arvalid_in & ~s_axi_rvalid_out;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  logic [RX_LANES-1:0] rd_hit_rx;
  logic [31:0] rx_map_word [RX_LANES];
  logic [31:0] rx_map_sel [RX_LANES];
  wire rd_hit_tx3 = (s_axi_araddr_in == OFS_TX_LANE3_MAP);
  wire rd_hit_ctrl = (s_axi_araddr_in == OFS_DATA_CTRL);
  wire rd_hit_master = (s_axi_araddr_in == OFS_MASTER_EN);
  wire rd_hit_float = (s_axi_araddr_in == OFS_TX_FLOAT);
  wire rd_mapped = rd_hit_tx3 | rd_hit_ctrl | rd_hit_master | rd_hit_float | (|rd_hit_rx);

  wire [31:0] tx3_word = {24'h000000, tx_lane3_on, 3'h0, tx_lane3_slot_select}; // RULE12
  wire [31:0] ctrl_word = {26'h0000000, rx_interleave, 3'h0, tx_interleave, 1'h0}; // RULE12
  wire [31:0] master_word = {31'h00000000, audio_master_enable}; // RULE12
  wire [31:0] float_word = {28'h0000000, tx_lane3_float_when_off, 3'h0}; // RULE12

  // Receive slot match per lane
  logic [RX_LANES-1:0] rx_hit;
  capture_mem_if #(.LANES(RX_LANES), .WORD_W(SAMPLE_W)) cap_if ();

  genvar n;
  generate
    for (n = 0; n < RX_LANES; n++) begin : g_rx
      assign wr_hit_rx[n] = (s_axi_awaddr_in == OFS_RX_MAP[n]);
      assign rd_hit_rx[n] = (s_axi_araddr_in == OFS_RX_MAP[n]);
      assign rx_map_word[n] = {24'h000000, rx_lane_on[n], 3'h0, rx_lane_slot_select[n]}; // RULE12
      if (n == 0) begin : g_first
        assign rx_map_sel[n] = rd_hit_rx[n] ? rx_map_word[n] : 32'h00000000;
      end else begin : g_next
        assign rx_map_sel[n] = rd_hit_rx[n] ? rx_map_word[n] : rx_map_sel[n-1];
      end

      // Interleave: the sample LSB names the even or odd lane of a pair
      assign rx_hit[n] = audio_master_enable & rx_lane_on[n] & rx_sample_valid_in // RULE3
        & (slot_index_in == rx_lane_slot_select[n]) // RULE2
        & (~rx_interleave | (rx_sample_in[0] == 1'(n % 2))); // RULE7 RULE8

      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          rx_lane_on[n] <= LANE_ON_RESET; // RULE3
          rx_lane_slot_select[n] <= RX_SLOT_RESET[n]; // RULE4
        end else if (wr_low & wr_hit_rx[n]) begin
          rx_lane_on[n] <= wbyte[BIT_LANE_ON]; // RULE3
          rx_lane_slot_select[n] <= wbyte[SLOT_W-1:0]; // RULE2
        end
      end
    end
  endgenerate

  wire [31:0] rd_word = rd_hit_tx3 ? tx3_word :
                        rd_hit_ctrl ? ctrl_word :
                        rd_hit_master ? master_word :
                        rd_hit_float ? float_word :
                        rx_map_sel[RX_LANES-1];

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_lane3_on <= LANE_ON_RESET; // RULE1
      tx_lane3_slot_select <= TX_LANE3_SLOT_RESET; // RULE5
      tx_lane3_float_when_off <= TX_FLOAT_RESET;
      rx_interleave <= INTERLEAVE_RESET;
      tx_interleave <= INTERLEAVE_RESET;
      audio_master_enable <= MASTER_EN_RESET; // RULE10
    end else if (wr_low) begin
      if (wr_hit_tx3) begin
        tx_lane3_on <= wbyte[BIT_LANE_ON]; // RULE1
        tx_lane3_slot_select <= wbyte[SLOT_W-1:0]; // RULE2
      end
      if (wr_hit_ctrl) begin
        rx_interleave <= wbyte[BIT_RX_INTERLEAVE]; // RULE7
        tx_interleave <= wbyte[BIT_TX_INTERLEAVE]; // RULE9
      end
      if (wr_hit_master) begin
        audio_master_enable <= wbyte[BIT_MASTER_EN]; // RULE10
      end
      if (wr_hit_float) begin
        tx_lane3_float_when_off <= wbyte[BIT_TX_LANE3_FLOAT];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s_axi_bvalid_out <= 1'h0;
      s_axi_bresp_out <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'h1;
      s_axi_bresp_out <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s_axi_rvalid_out <= 1'h0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid_out <= 1'h1;
      s_axi_rdata_out <= rd_word;
      s_axi_rresp_out <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'h0;
    end
  end

  // Receive capture: every matching lane stores the same sample
  assign cap_if.wr_en = rx_hit;
  assign cap_if.wr_data = rx_sample_in;
  assign cap_if.rd_addr = cap_rd_lane_in;
  assign cap_rd_data_out = cap_if.rd_data;

  pcm_capture_mem #(.LANES(RX_LANES), .WORD_W(SAMPLE_W)) u_capture (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .mem(cap_if.store)
  );

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_lane_got_out <= '0;
    end else begin
      rx_lane_got_out <= rx_hit;
    end
  end

  // Transmit lane 3: in interleave it owns its slot on odd frames only
  wire tx_slot_match = slot_tick_in & audio_master_enable
    & (slot_index_in == tx_lane3_slot_select); // RULE2 RULE10
  wire tx_own = ~tx_interleave | frame_parity; // RULE9
  wire tx_send = tx_slot_match & tx_own & tx_lane3_on; // RULE1
  wire [SAMPLE_W-1:0] tx_word = tx_interleave ?
    {tx_feed_lane3_in[SAMPLE_W-1:1], TX_LANE3_PARITY} : tx_feed_lane3_in; // RULE9

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      frame_parity <= 1'h0;
    end else if (frame_start_in) begin
      frame_parity <= ~frame_parity;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_data_out <= '0;
      tx_drive_out <= 1'h0;
      tx_feed_lane3_taken_out <= 1'h0;
    end else begin
      tx_feed_lane3_taken_out <= tx_send;
      if (tx_send) begin
        tx_data_out <= tx_word;
        tx_drive_out <= 1'h1;
      end else if (tx_slot_match & tx_own) begin
        tx_data_out <= '0; // RULE11
        tx_drive_out <= ~tx_lane3_float_when_off; // RULE11
      end else if (slot_tick_in) begin
        tx_data_out <= '0;
        tx_drive_out <= 1'h0;
      end
    end
  end

  assign audio_on_out = audio_master_enable; // RULE10

endmodule

// file: rtl/pcm_slot_map_pkg.sv
// Package: register map, field positions and reset values of the PCM slot map control
package pcm_slot_map_pkg;

  localparam int AXI_ADDR_W = 12;
  localparam int RX_LANES = 8;
  localparam int SLOT_W = 4;

  localparam logic [AXI_ADDR_W-1:0] OFS_TX_LANE3_MAP = 12'h0F0;
  localparam logic [AXI_ADDR_W-1:0] OFS_RX_MAP [RX_LANES] = '{
    12'h0F4, 12'h0F8, 12'h0FC, 12'h100, 12'h104, 12'h108, 12'h10C, 12'h110
  };
  localparam logic [AXI_ADDR_W-1:0] OFS_DATA_CTRL = 12'h114;
  localparam logic [AXI_ADDR_W-1:0] OFS_MASTER_EN = 12'h118;
  localparam logic [AXI_ADDR_W-1:0] OFS_TX_FLOAT = 12'h11C;

  localparam int BIT_LANE_ON = 7;
  localparam int BIT_RX_INTERLEAVE = 5;
  localparam int BIT_TX_INTERLEAVE = 1;
  localparam int BIT_MASTER_EN = 0;
  localparam int BIT_TX_LANE3_FLOAT = 3;

  localparam logic LANE_ON_RESET = 1'h0;
  localparam logic INTERLEAVE_RESET = 1'h0;
  localparam logic MASTER_EN_RESET = 1'h0;
  localparam logic TX_FLOAT_RESET = 1'h0;
  localparam logic [SLOT_W-1:0] TX_LANE3_SLOT_RESET = 4'h0;
  localparam logic [SLOT_W-1:0] RX_SLOT_RESET [RX_LANES] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7
  };

  // Lane index parity used to tag interleaved transmit samples
  localparam logic TX_LANE3_PARITY = 1'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: verif/pcm_far_end_model.sv
// Model: far end of the PCM bus, offering one slot and its sample per request
`timescale 1ns/1ps
module pcm_far_end_model (
  input wire logic core_clk_in,
  input wire logic send_in,
  input wire logic [3:0] slot_in,
  input wire logic [15:0] data_in,
  output logic frame_start_out = 1'b0,
  output logic slot_tick_out = 1'b0,
  output logic [3:0] slot_index_out = 4'h0,
  output logic sample_valid_out = 1'b0,
  output logic [15:0] sample_out = 16'h0
);
  always @(posedge core_clk_in) begin
    frame_start_out <= send_in && slot_in == 4'h0;
    slot_tick_out <= send_in;
    sample_valid_out <= send_in;
    slot_index_out <= slot_in;
    // Outside its slot the line toggles so stale data never looks fresh
    sample_out <= send_in ? data_in : ~sample_out;
  end
endmodule

// file: verif/pcm_slot_map_asserts.sv
// Checker: slot steering and readback relations at the control ports
`timescale 1ns/1ps
module pcm_slot_map_asserts
  import pcm_slot_map_pkg::*;
#(parameter int SAMPLE_W = 16) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic slot_tick_in,
  input wire logic rx_sample_valid_in,
  input wire logic tx_feed_lane3_taken_out,
  input wire logic [SAMPLE_W-1:0] tx_data_out,
  input wire logic tx_drive_out,
  input wire logic [RX_LANES-1:0] rx_lane_got_out,
  input wire logic audio_on_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence off_tick_s;
    slot_tick_in && !audio_on_out;
  endsequence
  a_read_rsvd_zero:
    assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0) else $error("rsvd");
  a_off_no_drive:
    assert property (off_tick_s |=> !tx_drive_out && tx_data_out == '0) else $error("drive");
  a_off_no_take:
    assert property (off_tick_s |=> !tx_feed_lane3_taken_out) else $error("take");
  a_off_no_capture:
    assert property (!audio_on_out |=> rx_lane_got_out == 8'h00) else $error("capture");
  a_take_drives_lane:
    assert property (tx_feed_lane3_taken_out |-> tx_drive_out) else $error("undriven");
  a_take_after_tick:
    assert property (tx_feed_lane3_taken_out |-> $past(slot_tick_in)) else $error("no tick");
  a_got_after_sample:
    assert property (rx_lane_got_out != 8'h00 |-> $past(rx_sample_valid_in)) else $error("got");
  a_slot_word_held:
    assert property (!slot_tick_in |=> $stable({tx_data_out, tx_drive_out})) else $error("hold");
endmodule

// file: verif/testbench.sv
// Testbench: registers, receive capture and transmit steering of the slot map control
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module testbench;
  import pcm_slot_map_pkg::*;
  logic core_clk_in = 0, reset_in = 1, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, psend = 0;
  logic s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0, par = 0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = 4'hF, slot_index_in, pslot = '0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, frame_start_in, slot_tick_in, rx_sample_valid_in, tx_drive_out;
  logic tx_feed_lane3_taken_out, audio_on_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [15:0] rx_sample_in, tx_data_out, cap_rd_data_out, tx_feed_lane3_in = '0, rnd = 16'h27;
  logic [7:0] rx_lane_got_out, eg;
  logic [2:0] cap_rd_lane_in = '0;
  logic [17:0] e;
  logic [33:0] er;
  logic [1:0] ew;
  int n_fail = 0, compares = 0;
  logic [33:0] exp_rd [$];
  logic [1:0] exp_wr [$];
  logic [7:0] exp_got [$];
  pcm_slot_map_control dut (.*);
  pcm_far_end_model far (.core_clk_in(core_clk_in), .send_in(psend), .slot_in(pslot),
    .data_in(tx_feed_lane3_in), .frame_start_out(frame_start_in), .slot_tick_out(slot_tick_in),
    .slot_index_out(slot_index_in), .sample_valid_out(rx_sample_valid_in),
    .sample_out(rx_sample_in));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic axi(input logic w, input logic [AXI_ADDR_W-1:0] a, input logic [33:0] d);
    logic t, b;
    if (!w) exp_rd.push_back(d);
    else exp_wr.push_back(d[33:32]);
    @(posedge core_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_araddr_in <= a;
    s_axi_wdata_in <= d[31:0];
    s_axi_awvalid_in <= w;
    s_axi_wvalid_in <= w;
    s_axi_bready_in <= w;
    s_axi_arvalid_in <= !w;
    s_axi_rready_in <= !w;
    do begin
      @(negedge core_clk_in);
      t = w ? s_axi_awready_out && s_axi_wready_out : s_axi_arready_out;
      b = w ? s_axi_bvalid_out : s_axi_rvalid_out;
      @(posedge core_clk_in);
      if (t) begin
        s_axi_awvalid_in <= 0;
        s_axi_wvalid_in <= 0;
        s_axi_arvalid_in <= 0;
      end
    end while (!b);
    s_axi_bready_in <= 0;
    s_axi_rready_in <= 0;
  endtask
  task automatic send(input logic [3:0] s, input logic [15:0] d);
    @(posedge core_clk_in);
    psend <= 1;
    pslot <= s;
    tx_feed_lane3_in <= d;
    cap_rd_lane_in <= s[2:0];
    if (s == 4'h0) par = !par;
    @(posedge core_clk_in);
    psend <= 0;
    repeat (2) @(negedge core_clk_in);
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #20 core_clk_in = ~core_clk_in;
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    end_of_test();
  end
  always @(posedge core_clk_in) begin
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      ew = exp_wr.pop_front();
      `CHK("write response", ew, s_axi_bresp_out)
    end
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      er = exp_rd.pop_front();
      `CHK("read word", er, {s_axi_rresp_out, s_axi_rdata_out})
    end
    if (!reset_in && rx_lane_got_out !== 8'h00) begin
      eg = exp_got.size() > 0 ? exp_got.pop_front() : 8'h00;
      `CHK("captured lanes", eg, rx_lane_got_out)
    end
  end
  initial begin
    repeat (12) @(posedge core_clk_in);
    reset_in <= 0;
    for (int i = 0; i < 12; i++)
      axi(0, OFS_TX_LANE3_MAP + 12'(4 * i), (i > 0 && i < 9) ? 34'(i - 1) : 34'h0);
    axi(0, 12'h120, {RESP_SLVERR, 32'h0});
    for (int i = 0; i < 13; i++)
      axi(1, OFS_TX_LANE3_MAP + 12'(4 * i), i < 12 ? 34'hFFFFFFFF : {RESP_SLVERR, 32'hFFFFFFFF});
    for (int i = 0; i < 12; i++)
      axi(0, OFS_TX_LANE3_MAP + 12'(4 * i), i < 9 ? 34'h8F : i == 9 ? 34'h22 : 34'(1 << (3 * (i - 10))));
    // A write without its low byte lane must leave the register as it was
    s_axi_wstrb_in <= 4'hE;
    axi(1, OFS_DATA_CTRL, 34'h0);
    s_axi_wstrb_in <= 4'hF;
    axi(0, OFS_DATA_CTRL, 34'h22);
    for (int i = 0; i < 8; i++)
      axi(1, OFS_RX_MAP[i], 34'h80 + 34'(i));
    axi(1, OFS_DATA_CTRL, 34'h0);
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      if (rnd[3:0] < 4'h8) exp_got.push_back(8'h01 << rnd[2:0]);
      send(rnd[3:0], rnd);
      @(negedge core_clk_in);
      if (rnd[3:0] < 4'h8) `CHK("stored sample", rnd, cap_rd_data_out)
    end
    axi(1, OFS_DATA_CTRL, 34'h20);
    axi(1, OFS_RX_MAP[0], 34'h85);
    axi(1, OFS_RX_MAP[1], 34'h85);
    // Lane 7 shares the odd slot but is off, so it must not capture
    axi(1, OFS_RX_MAP[7], 34'h05);
    exp_got.push_back(8'h01);
    send(4'h5, 16'h1234);
    exp_got.push_back(8'h22);
    send(4'h5, 16'h1235);
    axi(1, OFS_MASTER_EN, 34'h0);
    send(4'h5, 16'h1235);
    for (int j = 0; j < 6; j++) begin
      rnd = lfsr(rnd);
      axi(1, OFS_MASTER_EN, {33'h0, j != 4});
      axi(1, OFS_TX_LANE3_MAP, (j == 1 || j == 2) ? 34'h09 : 34'h89);
      axi(1, OFS_TX_FLOAT, {30'h0, j == 0 || j == 2, 3'h0});
      axi(1, OFS_DATA_CTRL, {32'h0, j == 5, 1'b0});
      if (j == 3) exp_got.push_back(8'h08);
      send(j == 3 ? 4'h3 : 4'h9, rnd);
      case (j)
        0: e = {2'b11, rnd};
        1: e = {2'b01, 16'h0};
        5: e = par ? {2'b11, rnd | 16'h1} : 18'h0;
        default: e = 18'h0;
      endcase
      `CHK("transmit slot", e, {tx_feed_lane3_taken_out, tx_drive_out, tx_data_out})
      `CHK("audio on", j != 4, audio_on_out)
    end
    repeat (4) @(posedge core_clk_in);
    `CHK("pending captures", 0, exp_got.size())
    end_of_test();
  end
endmodule
bind pcm_slot_map_control pcm_slot_map_asserts #(.SAMPLE_W(SAMPLE_W)) chk (.*);
